// >>> design/refclk_lock_and_rate_measure.sv
// Reference clock lock control and fine data-rate measurement with register port
`timescale 1ns/1ps
`default_nettype none

module refclk_lock_and_rate_measure
	import refclk_pkg::*;
(
	input  wire logic       clock,
	input  wire logic       rst,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	input  wire logic [7:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	output logic      [7:0] reg_rdata,
	input  wire logic       ref_in_pos,
	input  wire logic       ref_in_neg,
	input  wire logic       data_edge_in,
	input  wire logic       osc_edge_in,
	input  wire logic       core_lock_lost,
	input  wire logic       full_rate_flag,
	input  wire logic [3:0] rate_divider_field,
	output logic            lock_lost_out,
	output logic            ref_buffer_enable,
	output logic            ref_lock_mode,
	output logic            osc_adjust_up,
	output logic            osc_adjust_down,
	output logic            measure_active
);

	localparam int REF_POS  = 0;
	localparam int REF_NEG  = 1;
	localparam int DATA_PIN = 2;
	localparam int OSC_PIN  = 3;

	// Register fields
	logic [2:0]         recovery_mode_sel;
	logic               measure_enable;
	logic               measure_restart;
	logic               acquire_restart;
	logic               ref_buffer_powerdown;
	logic               lock_check_source;
	logic [1:0]         ref_band_sel;
	logic [3:0]         lock_ratio_code;
	logic               measure_done;
	logic [COUNT_W-1:0] measure_count;

	// Derived controls
	logic               lock_mode_on;
	logic               meas_mode_on;
	logic               ratio_valid;
	logic               meas_restart_evt;
	logic               acq_restart_evt;
	logic               wr_meas_ctrl;
	logic               wr_acq_ctrl;
	logic               ref_pulse;
	logic [COUNT_W-1:0] lock_target;
	logic [COUNT_W-1:0] compare_ref;
	logic [COUNT_W-1:0] osc_count;
	logic [COUNT_W-1:0] err_mag;
	logic               osc_slow;
	logic               within_gain;
	logic               beyond_lose;
	logic               meas_running;
	logic               lock_start;
	logic               meas_start;
	lock_state_t        lock_state;
	lock_state_t        next_lock_state;
	logic [7:0]         next_rdata;

	edge_if #(.N(SYNC_W)) pin_edges ();
	window_if             win ();

	pin_sync #(
		.N(SYNC_W)
	) u_pin_sync (
		.clock (clock),
		.rst   (rst),
		.pins  ({osc_edge_in, data_edge_in, ref_in_neg, ref_in_pos}),
		.sync  (pin_edges.src)
	);

	rate_window u_rate_window (
		.clock (clock),
		.rst   (rst),
		.w     (win.win)
	);

	assign wr_meas_ctrl = reg_wr && (reg_addr == ADDR_MEAS_CTRL);
	assign wr_acq_ctrl  = reg_wr && (reg_addr == ADDR_ACQ_CTRL);

	// Restarts act on the high-to-low write that completes the pulse
	assign meas_restart_evt = wr_meas_ctrl && measure_restart && !reg_wdata[MEAS_RST_BIT];
	assign acq_restart_evt  = wr_acq_ctrl && acquire_restart && !reg_wdata[ACQ_RST_BIT];

	assign lock_mode_on = (recovery_mode_sel == MODE_LOCK_REF) && !ref_buffer_powerdown;
	// Lock-to-reference wins if software breaks the exclusivity
	assign meas_mode_on = measure_enable && !ref_buffer_powerdown
		&& (recovery_mode_sel != MODE_LOCK_REF);
	assign ratio_valid  = (lock_ratio_code <= RATIO_MAX);

	// Differential buffer: a reference edge needs the pair apart and the buffer powered
	assign ref_pulse = pin_edges.rise[REF_POS] && !pin_edges.level[REF_NEG]
		&& !ref_buffer_powerdown;

	// At band 0 one window holds 2^11 divided-reference periods, so the oscillator aims at 2^(10+n)
	assign lock_target = COUNT_W'(1) << (LOCK_TARGET_LOG + int'(lock_ratio_code));
	assign osc_count   = win.count_b;
	assign compare_ref = (lock_check_source && lock_state == LK_TRACK)
		? win.count_a : lock_target;
	assign osc_slow    = osc_count < compare_ref;
	assign err_mag     = osc_slow ? (compare_ref - osc_count) : (osc_count - compare_ref);
	// Shift thresholds approximate 1000 and 250 ppm with power-of-two divisions
	assign beyond_lose = err_mag > (compare_ref >> TOL_LOSE_SHIFT);
	assign within_gain = err_mag <= (compare_ref >> TOL_GAIN_SHIFT);

	assign lock_start = lock_mode_on && (acq_restart_evt || lock_state == LK_OFF
		|| (win.done && lock_state != LK_OFF) || (!win.busy && !win.done));
	assign meas_start = meas_mode_on && meas_restart_evt;
	assign meas_running = meas_mode_on && win.busy;

	assign win.start     = lock_start || meas_start;
	assign win.band      = ref_band_sel;
	assign win.ref_pulse = ref_pulse;
	assign win.a_pulse   = pin_edges.rise[DATA_PIN];
	assign win.b_pulse   = pin_edges.rise[OSC_PIN];

	// Control register fields
	always_ff @(posedge clock) begin
		if (rst) begin
			recovery_mode_sel <= MODE_RESET;
			measure_enable    <= 1'b0;
			measure_restart   <= 1'b0;
		end else if (wr_meas_ctrl) begin
			recovery_mode_sel <= reg_wdata[MODE_MSB:MODE_LSB];
			measure_enable    <= reg_wdata[MEAS_EN_BIT];
			measure_restart   <= reg_wdata[MEAS_RST_BIT];
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			acquire_restart <= 1'b0;
		end else if (wr_acq_ctrl) begin
			acquire_restart <= reg_wdata[ACQ_RST_BIT];
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			ref_buffer_powerdown <= PDN_RESET;
		end else if (reg_wr && reg_addr == ADDR_POWER) begin
			ref_buffer_powerdown <= reg_wdata[PDN_BIT];
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			lock_check_source <= 1'b0;
			ref_band_sel      <= BAND_RESET;
			lock_ratio_code   <= RATIO_RESET;
		end else if (reg_wr && reg_addr == ADDR_LOCK_CFG) begin
			lock_check_source <= reg_wdata[SRC_BIT];
			ref_band_sel      <= reg_wdata[BAND_MSB:BAND_LSB];
			lock_ratio_code   <= reg_wdata[RATIO_MSB:RATIO_LSB];
		end
	end

	// Completion flag; window end wins, a restart in that cycle would restart the window anyway
	always_ff @(posedge clock) begin
		if (rst) begin
			measure_done <= 1'b0;
		end else if (meas_mode_on && win.done) begin
			measure_done <= 1'b1;
		end else if (meas_restart_evt) begin
			measure_done <= 1'b0;
		end
	end

	// Result bytes change only when a window completes
	always_ff @(posedge clock) begin
		if (rst) begin
			measure_count <= '0;
		end else if (meas_mode_on && win.done) begin
			measure_count <= win.count_a;
		end
	end

	// Lock state machine
	always_comb begin
		next_lock_state = lock_state;
		unique case (lock_state)
			LK_OFF: begin
				if (lock_mode_on) begin
					next_lock_state = LK_ACQUIRE;
				end
			end
			LK_ACQUIRE: begin
				if (!lock_mode_on) begin
					next_lock_state = LK_OFF;
				end else if (acq_restart_evt) begin
					next_lock_state = LK_ACQUIRE;
				end else if (win.done && ratio_valid && within_gain) begin
					next_lock_state = LK_TRACK;
				end
			end
			LK_TRACK: begin
				if (!lock_mode_on) begin
					next_lock_state = LK_OFF;
				end else if (acq_restart_evt) begin
					next_lock_state = LK_ACQUIRE;
				end else if (win.done && beyond_lose) begin
					next_lock_state = LK_ACQUIRE;
				end
			end
			default: begin
				next_lock_state = LK_OFF;
			end
		endcase
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			lock_state <= LK_OFF;
		end else begin
			lock_state <= next_lock_state;
		end
	end

	// Frequency loop steps only while acquiring; tracking leaves the output clock steady
	always_ff @(posedge clock) begin
		if (rst) begin
			osc_adjust_up   <= 1'b0;
			osc_adjust_down <= 1'b0;
		end else begin
			osc_adjust_up   <= 1'b0;
			osc_adjust_down <= 1'b0;
			if (lock_mode_on && lock_state == LK_ACQUIRE && win.done && ratio_valid
				&& !within_gain) begin
				osc_adjust_up   <= osc_slow;
				osc_adjust_down <= !osc_slow;
			end
		end
	end

	// Pin outputs, one register each
	always_ff @(posedge clock) begin
		if (rst) begin
			lock_lost_out <= 1'b1;
		end else begin
			lock_lost_out <= lock_mode_on ? (next_lock_state != LK_TRACK)
				: core_lock_lost;
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			ref_buffer_enable <= 1'b0;
		end else begin
			ref_buffer_enable <= !ref_buffer_powerdown;
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			ref_lock_mode <= 1'b0;
		end else begin
			ref_lock_mode <= lock_mode_on;
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			measure_active <= 1'b0;
		end else begin
			measure_active <= meas_running;
		end
	end

	// Register readback, unmapped addresses read zero
	always_comb begin
		next_rdata = 8'h00;
		unique case (reg_addr)
			ADDR_RATE_DIV: begin
				next_rdata[FULL_RATE_BIT]    = full_rate_flag;
				next_rdata[DIV_MSB:DIV_LSB] = rate_divider_field;
			end
			ADDR_STATUS: begin
				next_rdata[DONE_BIT]      = measure_done;
				next_rdata[LOCK_LOST_BIT] = lock_lost_out;
				next_rdata[CFG_ERR_BIT]   = !ratio_valid;
			end
			ADDR_MEAS_CTRL: begin
				next_rdata[MODE_MSB:MODE_LSB] = recovery_mode_sel;
				next_rdata[MEAS_EN_BIT]       = measure_enable;
				next_rdata[MEAS_RST_BIT]      = measure_restart;
			end
			ADDR_ACQ_CTRL: begin
				next_rdata[ACQ_RST_BIT] = acquire_restart;
			end
			ADDR_POWER: begin
				next_rdata[PDN_BIT] = ref_buffer_powerdown;
			end
			ADDR_LOCK_CFG: begin
				next_rdata[SRC_BIT]             = lock_check_source;
				next_rdata[BAND_MSB:BAND_LSB]   = ref_band_sel;
				next_rdata[RATIO_MSB:RATIO_LSB] = lock_ratio_code;
			end
			ADDR_COUNT_HIGH: next_rdata = measure_count[23:16];
			ADDR_COUNT_MID:  next_rdata = measure_count[15:8];
			ADDR_COUNT_LOW:  next_rdata = measure_count[7:0];
			default:         next_rdata = 8'h00;
		endcase
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			reg_rdata <= next_rdata;
		end
	end

endmodule : refclk_lock_and_rate_measure

`default_nettype wire

// >>> include/refclk_pkg.sv
// Register map, field layout, reset values and timing counts of the reference clock block
package refclk_pkg;

	localparam logic [7:0] ADDR_RATE_DIV   = 8'h05;
	localparam logic [7:0] ADDR_STATUS     = 8'h06;
	localparam logic [7:0] ADDR_MEAS_CTRL  = 8'h08;
	localparam logic [7:0] ADDR_ACQ_CTRL   = 8'h09;
	localparam logic [7:0] ADDR_POWER      = 8'h0a;
	localparam logic [7:0] ADDR_LOCK_CFG   = 8'h0f;
	localparam logic [7:0] ADDR_COUNT_HIGH = 8'h10;
	localparam logic [7:0] ADDR_COUNT_MID  = 8'h11;
	localparam logic [7:0] ADDR_COUNT_LOW  = 8'h12;

	localparam int MODE_LSB      = 4;
	localparam int MODE_MSB      = 6;
	localparam int MEAS_EN_BIT   = 1;
	localparam int MEAS_RST_BIT  = 0;
	localparam int ACQ_RST_BIT   = 6;
	localparam int PDN_BIT       = 2;
	localparam int SRC_BIT       = 6;
	localparam int BAND_LSB      = 4;
	localparam int BAND_MSB      = 5;
	localparam int RATIO_LSB     = 0;
	localparam int RATIO_MSB     = 3;
	localparam int DONE_BIT      = 0;
	localparam int LOCK_LOST_BIT = 1;
	localparam int CFG_ERR_BIT   = 3;
	localparam int FULL_RATE_BIT = 6;
	localparam int DIV_LSB       = 2;
	localparam int DIV_MSB       = 5;

	localparam logic [2:0] MODE_LOCK_REF = 3'h2;
	localparam logic [2:0] MODE_RESET    = 3'h0;
	localparam logic       PDN_RESET     = 1'b1;
	localparam logic [1:0] BAND_RESET    = 2'h0;
	localparam logic [3:0] RATIO_RESET   = 4'h0;
	localparam logic [3:0] RATIO_MAX     = 4'ha;

	localparam int COUNT_W         = 24;
	localparam int WIN_BASE_LOG    = 11;
	localparam int WIN_CNT_W       = WIN_BASE_LOG + 4;
	localparam int LOCK_TARGET_LOG = 10;
	localparam int TOL_LOSE_SHIFT  = 10;
	localparam int TOL_GAIN_SHIFT  = 12;
	localparam int SYNC_W          = 4;

	typedef enum logic [2:0] {
		LK_OFF     = 3'b001,
		LK_ACQUIRE = 3'b010,
		LK_TRACK   = 3'b100
	} lock_state_t;

endpackage : refclk_pkg

// >>> include/refclk_ifs.sv
// Interfaces joining the reference clock block to its synchroniser and counting window
`timescale 1ns/1ps
`default_nettype none

interface edge_if #(parameter int N = 4);
	logic [N-1:0] level;
	logic [N-1:0] rise;
	modport src (output level, output rise);
	modport dst (input level, input rise);
endinterface : edge_if

interface window_if;
	import refclk_pkg::*;
	logic               start;
	logic [1:0]         band;
	logic               ref_pulse;
	logic               a_pulse;
	logic               b_pulse;
	logic [COUNT_W-1:0] count_a;
	logic [COUNT_W-1:0] count_b;
	logic               busy;
	logic               done;
	modport ctrl (output start, output band, output ref_pulse, output a_pulse, output b_pulse,
		input count_a, input count_b, input busy, input done);
	modport win (input start, input band, input ref_pulse, input a_pulse, input b_pulse,
		output count_a, output count_b, output busy, output done);
endinterface : window_if

`default_nettype wire

// >>> design/pin_sync.sv
// Two-stage synchroniser with rising-edge detect for the pin inputs
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
	parameter int N = 4
) (
	input  wire logic         clock,
	input  wire logic         rst,
	input  wire logic [N-1:0] pins,
	edge_if.src               sync
);

	logic [N-1:0] stage1;
	logic [N-1:0] stage2;
	logic [N-1:0] stage3;

	// Stage one feeds stage two only; edges come from stages two and three
	always_ff @(posedge clock) begin
		if (rst) begin
			stage1 <= '0;
			stage2 <= '0;
			stage3 <= '0;
		end else begin
			stage1 <= pins;
			stage2 <= stage1;
			stage3 <= stage2;
		end
	end

	assign sync.level = stage2;
	assign sync.rise  = stage2 & ~stage3;

endmodule : pin_sync

`default_nettype wire

// >>> design/rate_window.sv
// Counting window of 2^(11+band) reference edges over two event streams
`timescale 1ns/1ps
`default_nettype none

module rate_window
	import refclk_pkg::*;
(
	input  wire logic clock,
	input  wire logic rst,
	window_if.win     w
);

	logic [WIN_CNT_W-1:0] ref_count;
	logic [WIN_CNT_W-1:0] last_ref;
	logic                 busy;
	logic                 done;
	logic [COUNT_W-1:0]   count_a;
	logic [COUNT_W-1:0]   count_b;

	assign last_ref = (WIN_CNT_W'(1) << (WIN_BASE_LOG + int'(w.band))) - WIN_CNT_W'(1);

	always_ff @(posedge clock) begin
		if (rst) begin
			busy      <= 1'b0;
			done      <= 1'b0;
			ref_count <= '0;
			count_a   <= '0;
			count_b   <= '0;
		end else begin
			done <= 1'b0;
			if (w.start) begin
				busy      <= 1'b1;
				ref_count <= '0;
				count_a   <= '0;
				count_b   <= '0;
			end else if (busy) begin
				count_a <= count_a + COUNT_W'(w.a_pulse);
				count_b <= count_b + COUNT_W'(w.b_pulse);
				if (w.ref_pulse) begin
					ref_count <= ref_count + WIN_CNT_W'(1);
					if (ref_count == last_ref) begin
						busy <= 1'b0;
						done <= 1'b1;
					end
				end
			end
		end
	end

	assign w.busy    = busy;
	assign w.done    = done;
	assign w.count_a = count_a;
	assign w.count_b = count_b;

endmodule : rate_window

`default_nettype wire

// >>> sim/refclk_properties.sv
// Port-level assertions for the reference clock block
`timescale 1ns/1ps
`default_nettype none
module refclk_checker
	import refclk_pkg::*;
(
	input wire logic       clock,
	input wire logic       rst,
	input wire logic       reg_wr,
	input wire logic       reg_rd,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata,
	input wire logic       core_lock_lost,
	input wire logic       lock_lost_out,
	input wire logic       ref_buffer_enable,
	input wire logic       ref_lock_mode,
	input wire logic       osc_adjust_up,
	input wire logic       osc_adjust_down
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);
	a_reset_outputs: assert property (disable iff (1'b0) rst |=> lock_lost_out &&
		!ref_buffer_enable && !ref_lock_mode) else $error("outputs not at reset level");
	a_lock_needs_buffer: assert property (ref_lock_mode |-> ref_buffer_enable)
		else $error("lock mode without reference buffer");
	a_adjust_in_acquire: assert property ((osc_adjust_up || osc_adjust_down) |->
		ref_lock_mode && lock_lost_out) else $error("adjust pulse outside acquisition");
	a_adjust_one_cycle: assert property ((osc_adjust_up || osc_adjust_down) |=>
		!osc_adjust_up && !osc_adjust_down) else $error("adjust pulse too long");
	a_unmapped_read: assert property (reg_rd && reg_addr == 8'h07 |=> reg_rdata == 8'h00)
		else $error("unmapped read not zero");
	a_rdata_holds: assert property (!reg_rd |=> $stable(reg_rdata))
		else $error("read data moved without read");
	a_lock_release: assert property ($fell(lock_lost_out) |-> ref_lock_mode ||
		!$past(core_lock_lost)) else $error("loss of lock released without cause");
	a_powerdown_write: assert property (reg_wr && reg_addr == ADDR_POWER ##1
		!(reg_wr && reg_addr == ADDR_POWER) |=> ref_buffer_enable == !$past(reg_wdata[PDN_BIT], 2))
		else $error("buffer enable not following power-down bit");
endmodule : refclk_checker
bind refclk_lock_and_rate_measure refclk_checker u_checker (.clock(clock), .rst(rst),
	.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_rdata(reg_rdata), .core_lock_lost(core_lock_lost), .lock_lost_out(lock_lost_out),
	.ref_buffer_enable(ref_buffer_enable), .ref_lock_mode(ref_lock_mode),
	.osc_adjust_up(osc_adjust_up), .osc_adjust_down(osc_adjust_down));
`default_nettype wire

// >>> sim/ref_source.sv
// Behavioural reference source with recovered data and oscillator edges
`timescale 1ns/1ps
`default_nettype none
module ref_source (
	input  wire logic ref_on,
	input  wire logic osc_fast,
	output logic      ref_pos,
	output logic      ref_neg,
	output logic      data_edge,
	output logic      osc_edge
);
	// Reference stands still until applied, as an unused input would
	initial begin
		ref_pos = 1'b0;
		forever #160 ref_pos = ref_on & ~ref_pos;
	end
	assign ref_neg = ~ref_pos;
	initial begin
		data_edge = 1'b0;
		#5;
		forever #80 data_edge = ~data_edge;
	end
	// Oscillator ignores adjust pulses; the bench moves it on purpose
	initial begin
		osc_edge = 1'b0;
		forever #(osc_fast ? 78 : 80) osc_edge = ~osc_edge;
	end
endmodule : ref_source
`default_nettype wire

// >>> sim/refclk_lock_and_rate_measure_tb.sv
// Self-checking bench for the reference clock block
`timescale 1ns/1ps
`default_nettype none
module refclk_lock_and_rate_measure_tb;
	import refclk_pkg::*;
	typedef struct packed {
		logic       wr;
		logic [7:0] addr;
		logic [7:0] wdata;
		logic [7:0] mask;
		logic [7:0] exp;
	} row_t;
	logic        clock, rst, reg_wr, reg_rd, core_lock_lost, ref_on, osc_fast;
	logic        ref_pos, ref_neg, data_edge, osc_edge, lock_lost_out, ref_buffer_enable;
	logic        ref_lock_mode, osc_adjust_up, osc_adjust_down, measure_active;
	logic [7:0]  reg_addr, reg_wdata, reg_rdata, rd;
	logic [23:0] cnt;
	int          err_count = 0;
	int          samples_checked = 0;
	int          n, downs = 0, ups = 0;
	row_t        rows [8] = '{
		'{1'b1, ADDR_LOCK_CFG, 8'h7a, 8'h7f, 8'h7a},
		'{1'b1, ADDR_LOCK_CFG, 8'h0b, 8'h7f, 8'h0b},
		'{1'b0, ADDR_STATUS, 8'h00, 8'h08, 8'h08},
		'{1'b1, ADDR_POWER, 8'h00, 8'h04, 8'h00},
		'{1'b1, ADDR_MEAS_CTRL, 8'h52, 8'h73, 8'h52},
		'{1'b1, 8'h07, 8'hff, 8'hff, 8'h00},
		'{1'b1, ADDR_COUNT_MID, 8'hff, 8'hff, 8'h00},
		'{1'b0, ADDR_RATE_DIV, 8'h00, 8'h7c, 8'h54}};
	ref_source partner (.ref_on(ref_on), .osc_fast(osc_fast), .ref_pos(ref_pos),
		.ref_neg(ref_neg), .data_edge(data_edge), .osc_edge(osc_edge));
	refclk_lock_and_rate_measure dut (.clock(clock), .rst(rst), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.ref_in_pos(ref_pos), .ref_in_neg(ref_neg), .data_edge_in(data_edge),
		.osc_edge_in(osc_edge), .core_lock_lost(core_lock_lost), .full_rate_flag(1'b1),
		.rate_divider_field(4'h5), .lock_lost_out(lock_lost_out),
		.ref_buffer_enable(ref_buffer_enable), .ref_lock_mode(ref_lock_mode),
		.osc_adjust_up(osc_adjust_up), .osc_adjust_down(osc_adjust_down),
		.measure_active(measure_active));
	task automatic check_val(input string what, input logic [23:0] exp, input logic [23:0] got);
		samples_checked++;
		if (got !== exp) begin
			err_count++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask : check_val
	task automatic check_near(input string what, input int exp, input int tol,
		input logic [23:0] got);
		samples_checked++;
		if ((^got) === 1'bx || got + tol < exp || got > exp + tol) begin
			err_count++;
			$display("wrong value %s expected %0d seen %0d", what, exp, got);
		end
	endtask : check_near
	task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge clock);
		reg_wr <= 1'b0;
	endtask : reg_write
	task automatic reg_read(input logic [7:0] a);
		@(posedge clock);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge clock);
		reg_rd <= 1'b0;
		#1 rd = reg_rdata;
	endtask : reg_read
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : print_verdict
	initial begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end
	// Bound covers four lock windows and one measurement with margin
	initial begin
		repeat (90000) @(posedge clock);
		err_count++;
		print_verdict();
	end
	always @(posedge clock) begin
		if (osc_adjust_down === 1'b1) downs++;
		if (osc_adjust_up === 1'b1) ups++;
	end
	initial begin
		rst = 1'b1;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		core_lock_lost = 1'b1;
		ref_on = 1'b0;
		osc_fast = 1'b1;
		repeat (12) @(posedge clock);
		rst <= 1'b0;
		core_lock_lost <= 1'b0;
		for (int i = 0; i < 8; i++) begin
			if (rows[i].wr) reg_write(rows[i].addr, rows[i].wdata);
			reg_read(rows[i].addr);
			check_val($sformatf("reg %h", rows[i].addr), rows[i].exp, rd & rows[i].mask);
		end
		@(posedge clock);
		core_lock_lost <= 1'b1;
		repeat (2) @(posedge clock);
		#1;
		check_val("lock lost from core", 1, lock_lost_out);
		@(posedge clock);
		rst <= 1'b1;
		core_lock_lost <= 1'b0;
		repeat (2) @(posedge clock);
		#1;
		check_val("lock lost in reset", 1, lock_lost_out);
		check_val("buffer in reset", 0, ref_buffer_enable);
		@(posedge clock);
		rst <= 1'b0;
		reg_read(ADDR_LOCK_CFG);
		check_val("cfg reset", 8'h00, rd & 8'h7f);
		reg_read(ADDR_POWER);
		check_val("pdn reset", 8'h04, rd & 8'h04);
		ref_on <= 1'b1;
		reg_write(ADDR_POWER, 8'h00);
		reg_write(ADDR_MEAS_CTRL, 8'h02);
		reg_write(ADDR_MEAS_CTRL, 8'h03);
		reg_write(ADDR_MEAS_CTRL, 8'h02);
		repeat (3) @(posedge clock);
		#1;
		check_val("active", 1, measure_active);
		n = 3;
		while (measure_active !== 1'b0 && n < 20000) begin
			@(posedge clock);
			n++;
		end
		check_near("window cycles", 16384, 24, n[23:0]);
		reg_read(ADDR_STATUS);
		check_val("done", 8'h01, rd & 8'h03);
		reg_read(ADDR_COUNT_HIGH);
		cnt[23:16] = rd;
		reg_read(ADDR_COUNT_MID);
		cnt[15:8] = rd;
		reg_read(ADDR_COUNT_LOW);
		cnt[7:0] = rd;
		check_near("rate count", 4096, 2, cnt);
		reg_write(ADDR_MEAS_CTRL, 8'h03);
		reg_write(ADDR_MEAS_CTRL, 8'h02);
		reg_read(ADDR_STATUS);
		check_val("done cleared", 8'h00, rd & 8'h01);
		check_val("second window", 1, measure_active);
		reg_write(ADDR_LOCK_CFG, 8'h42);
		reg_write(ADDR_MEAS_CTRL, 8'h20);
		reg_write(ADDR_ACQ_CTRL, 8'h40);
		reg_write(ADDR_ACQ_CTRL, 8'h00);
		check_val("lock mode", 1, ref_lock_mode);
		n = 0;
		while (downs == 0 && n < 20000) begin
			@(posedge clock);
			n++;
		end
		check_val("adjust down only", 1, downs > 0 && ups == 0);
		osc_fast <= 1'b0;
		n = 0;
		while (lock_lost_out !== 1'b0 && n < 20000) begin
			@(posedge clock);
			n++;
		end
		check_val("locked", 0, lock_lost_out);
		osc_fast <= 1'b1;
		n = 0;
		while (lock_lost_out !== 1'b1 && n < 20000) begin
			@(posedge clock);
			n++;
		end
		check_val("lock lost", 1, lock_lost_out);
		check_val("mode held", 1, ref_lock_mode);
		reg_write(ADDR_LOCK_CFG, 8'h43);
		reg_write(ADDR_ACQ_CTRL, 8'h40);
		reg_write(ADDR_ACQ_CTRL, 8'h00);
		n = 0;
		while (ups == 0 && n < 20000) begin
			@(posedge clock);
			n++;
		end
		check_val("adjust up", 1, ups > 0);
		print_verdict();
	end
endmodule : refclk_lock_and_rate_measure_tb
`default_nettype wire
